// [humidity_link_pkg.sv]
// Constants, commands and states of the humidity sensor link controller.
// Assumes a 125 MHz system clock and an open-drain data line with a pull-up.
// Overview of operation
// - No command before 11 ms after power-up.
// - Data changes after falling edge, sampled rising.
// - Data stable while clock is high.
// - Controller only pulls data low, else releases.
// - Frame start: fall, clock pulse, rise.
// - Word is address 000 then command, MSB first.
// - Command codes for measure, status, reset.
// - Soft reset, then wait 11 ms.
// - Clock resumes only after data-ready low.
// - Two bytes, checksum, each acknowledged low.
// - Acknowledge high after low byte skips checksum.
// - Keep measuring below ten percent duty.
// - Connection reset: nine clocks, then frame start.
package humidity_link_pkg;
  localparam int          CLK_HZ       = 125_000_000;
  localparam int          T_POWERUP_MS = 11;
  localparam int          POWERUP_CYC  = T_POWERUP_MS * (CLK_HZ / 1000);
  localparam int          T_QUARTER_NS = 250;
  localparam int          QUARTER_CYC  = (T_QUARTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int          COOL_FACTOR  = 9;
  localparam int          RST_CLOCKS   = 9;
  localparam int          ADDR_BITS    = 3;
  localparam int          ACK_SLOT     = 8;
  localparam int          MEAS_BYTES   = 3;
  localparam int          STAT_BYTES   = 2;
  localparam logic [2:0]  DEV_ADDR     = 3'h0;
  localparam logic [4:0]  CMD_MEAS_T   = 5'h03;
  localparam logic [4:0]  CMD_MEAS_RH  = 5'h05;
  localparam logic [4:0]  CMD_STAT_RD  = 5'h07;
  localparam logic [4:0]  CMD_STAT_WR  = 5'h06;
  localparam logic [4:0]  CMD_SOFT_RST = 5'h1e;
  localparam logic [7:0]  CRC_POLY     = 8'h31;
  localparam logic [7:0]  CRC_INIT     = 8'h00;

  typedef enum logic [3:0] {
    st_power,
    st_idle,
    st_rst_clk,
    st_ts,
    st_send,
    st_wait_rdy,
    st_read,
    st_hold,
    st_cool
  } state_t;
endpackage : humidity_link_pkg

// [humidity_host.sv]
// Controller that drives the humidity sensor link: clock out, open-drain data.
// Assumes an external pull-up on the data line and a user that waits for cmd_ready.
`timescale 1ns/100ps
module humidity_host #(
  parameter int POWERUP_CYCLES = humidity_link_pkg::POWERUP_CYC,
  parameter int QUARTER        = humidity_link_pkg::QUARTER_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        cmd_valid,
  input  wire logic [4:0]  cmd_code,
  input  wire logic [7:0]  wr_data,
  input  wire logic        skip_crc,
  input  wire logic        link_reset,
  input  wire logic        sda_in,
  output logic             sck,
  output logic             sda_out,
  output logic             sda_oe_n,
  output logic             cmd_ready,
  output logic             done,
  output logic [15:0]      result,
  output logic             crc_ok,
  output logic             ack_err
);
  localparam int QW = $clog2(QUARTER + 1);

  humidity_link_pkg::state_t st;
  logic [QW-1:0] qcnt;
  logic          tick;
  logic          sda_s1;
  logic          sda_s2;
  logic [1:0]    ph;
  logic [2:0]    ts_step;
  logic [3:0]    bit_cnt;
  logic [1:0]    byte_cnt;
  logic [1:0]    last_idx;
  logic [7:0]    shreg;
  logic [7:0]    rx;
  logic [7:0]    crc;
  logic [4:0]    cmd;
  logic [7:0]    wdata;
  logic [31:0]   wait_cnt;
  logic [31:0]   meas_cnt;
  logic          cmd_pend;
  logic          wr_pend;
  logic          need_rst;
  logic          seen_high;
  logic          skip;
  logic          is_meas;
  logic          booted;
  logic          end_early;

  function automatic logic [7:0] crc_next(input logic [7:0] c, input logic b);
    crc_next = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? humidity_link_pkg::CRC_POLY : 8'h00);
  endfunction : crc_next

  // Two flip-flops bring the data pin into the clock domain.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
    end
  end

  // Quarter-period time base for the serial clock.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      qcnt <= '0;
    end else if (tick) begin
      qcnt <= '0;
    end else begin
      qcnt <= qcnt + 1'b1;
    end
  end

  assign tick      = (qcnt == QW'(QUARTER - 1));
  assign end_early = skip && (byte_cnt == last_idx - 2'h1);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st        <= humidity_link_pkg::st_power;
      sck       <= 1'b0;
      sda_oe_n  <= 1'b1;
      cmd_ready <= 1'b0;
      done      <= 1'b0;
      result    <= 16'h0000;
      crc_ok    <= 1'b0;
      ack_err   <= 1'b0;
      ph        <= 2'h0;
      ts_step   <= 3'h0;
      bit_cnt   <= 4'h0;
      byte_cnt  <= 2'h0;
      last_idx  <= 2'h0;
      shreg     <= 8'h00;
      rx        <= 8'h00;
      crc       <= humidity_link_pkg::CRC_INIT;
      cmd       <= 5'h00;
      wdata     <= 8'h00;
      wait_cnt  <= 32'h0000_0000;
      meas_cnt  <= 32'h0000_0000;
      cmd_pend  <= 1'b0;
      wr_pend   <= 1'b0;
      need_rst  <= 1'b0;
      seen_high <= 1'b0;
      skip      <= 1'b0;
      is_meas   <= 1'b0;
      booted    <= 1'b0;
    end else begin
      done <= 1'b0;
      case (st)
        humidity_link_pkg::st_power: begin
          wait_cnt <= wait_cnt + 32'h0000_0001;
          if (wait_cnt == 32'(POWERUP_CYCLES - 1)) begin
            st        <= humidity_link_pkg::st_idle;
            cmd_ready <= 1'b1;
            booted    <= 1'b1;
          end
        end
        humidity_link_pkg::st_idle: begin
          ph      <= 2'h0;
          bit_cnt <= 4'h0;
          ts_step <= 3'h0;
          if (cmd_valid || link_reset) begin
            cmd_ready <= 1'b0;
            cmd_pend  <= cmd_valid;
            cmd       <= cmd_code;
            wdata     <= wr_data;
            skip      <= skip_crc;
            crc_ok    <= 1'b0;
            ack_err   <= 1'b0;
            st <= (link_reset || need_rst) ? humidity_link_pkg::st_rst_clk
                                           : humidity_link_pkg::st_ts;
          end
        end
        humidity_link_pkg::st_rst_clk: begin
          if (tick) begin
            ph <= ph + 2'h1;
            if (ph == 2'h1) begin
              sck <= 1'b1;
            end
            if (ph == 2'h3) begin
              sck     <= 1'b0;
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == 4'(humidity_link_pkg::RST_CLOCKS - 1)) begin
                bit_cnt  <= 4'h0;
                need_rst <= 1'b0;
                st       <= humidity_link_pkg::st_ts;
              end
            end
          end
        end
        humidity_link_pkg::st_ts: begin
          if (tick) begin
            ts_step <= ts_step + 3'h1;
            case (ts_step)
              3'h0: sck <= 1'b1;
              3'h1: sda_oe_n <= 1'b0;
              3'h2: sck <= 1'b0;
              3'h3: sck <= 1'b1;
              3'h4: sda_oe_n <= 1'b1;
              default: begin
                sck      <= 1'b0;
                ph       <= 2'h0;
                byte_cnt <= 2'h0;
                shreg    <= {humidity_link_pkg::DEV_ADDR, cmd};
                crc      <= humidity_link_pkg::CRC_INIT;
                wr_pend  <= (cmd == humidity_link_pkg::CMD_STAT_WR);
                if (cmd_pend) begin
                  st <= humidity_link_pkg::st_send;
                end else begin
                  st        <= humidity_link_pkg::st_idle;
                  cmd_ready <= 1'b1;
                  done      <= 1'b1;
                end
              end
            endcase
          end
        end
        humidity_link_pkg::st_send: begin
          if (tick) begin
            ph <= ph + 2'h1;
            case (ph)
              2'h0: sda_oe_n <= (bit_cnt == 4'(humidity_link_pkg::ACK_SLOT)) ? 1'b1 : shreg[7];
              2'h1: sck <= 1'b1;
              2'h2: sck <= 1'b1;
              default: begin
                sck <= 1'b0;
                if (bit_cnt != 4'(humidity_link_pkg::ACK_SLOT)) begin
                  crc     <= crc_next(crc, shreg[7]);
                  shreg   <= {shreg[6:0], 1'b0};
                  bit_cnt <= bit_cnt + 4'h1;
                end else begin
                  bit_cnt <= 4'h0;
                  if (sda_s2) begin
                    ack_err   <= 1'b1;
                    need_rst  <= 1'b1;
                    done      <= 1'b1;
                    cmd_ready <= 1'b1;
                    st        <= humidity_link_pkg::st_idle;
                  end else if (wr_pend) begin
                    wr_pend  <= 1'b0;
                    shreg    <= wdata;
                    byte_cnt <= 2'h1;
                  end else if (cmd == humidity_link_pkg::CMD_SOFT_RST) begin
                    wait_cnt <= 32'h0000_0000;
                    st       <= humidity_link_pkg::st_hold;
                  end else if (cmd == humidity_link_pkg::CMD_MEAS_T ||
                               cmd == humidity_link_pkg::CMD_MEAS_RH) begin
                    is_meas   <= 1'b1;
                    last_idx  <= 2'(humidity_link_pkg::MEAS_BYTES - 1);
                    seen_high <= 1'b0;
                    meas_cnt  <= 32'h0000_0000;
                    st        <= humidity_link_pkg::st_wait_rdy;
                  end else if (cmd == humidity_link_pkg::CMD_STAT_RD) begin
                    is_meas  <= 1'b0;
                    last_idx <= 2'(humidity_link_pkg::STAT_BYTES - 1);
                    byte_cnt <= 2'h0;
                    st       <= humidity_link_pkg::st_read;
                  end else begin
                    done      <= 1'b1;
                    cmd_ready <= 1'b1;
                    st        <= humidity_link_pkg::st_idle;
                  end
                end
              end
            endcase
          end
        end
        humidity_link_pkg::st_wait_rdy: begin
          meas_cnt <= meas_cnt + 32'h0000_0001;
          byte_cnt <= 2'h0;
          ph       <= 2'h0;
          if (sda_s2) begin
            seen_high <= 1'b1;
          end
          if (seen_high && !sda_s2) begin
            st <= humidity_link_pkg::st_read;
          end
        end
        humidity_link_pkg::st_read: begin
          if (tick) begin
            ph <= ph + 2'h1;
            case (ph)
              2'h0: sda_oe_n <= !(bit_cnt == 4'(humidity_link_pkg::ACK_SLOT) && !end_early);
              2'h1: sck <= 1'b1;
              2'h2: sck <= 1'b1;
              default: begin
                sck <= 1'b0;
                if (bit_cnt != 4'(humidity_link_pkg::ACK_SLOT)) begin
                  rx      <= {rx[6:0], sda_s2};
                  bit_cnt <= bit_cnt + 4'h1;
                  if (byte_cnt != last_idx) begin
                    crc <= crc_next(crc, sda_s2);
                  end
                end else begin
                  bit_cnt  <= 4'h0;
                  byte_cnt <= byte_cnt + 2'h1;
                  if (byte_cnt != last_idx) begin
                    result <= {result[7:0], rx};
                  end
                  if (byte_cnt == last_idx) begin
                    crc_ok <= (rx == crc);
                  end
                  if (end_early || byte_cnt == last_idx) begin
                    sda_oe_n <= 1'b1;
                    done     <= 1'b1;
                    if (is_meas) begin
                      wait_cnt <= 32'(meas_cnt * 32'(humidity_link_pkg::COOL_FACTOR));
                      st       <= humidity_link_pkg::st_cool;
                    end else begin
                      cmd_ready <= 1'b1;
                      st        <= humidity_link_pkg::st_idle;
                    end
                  end
                end
              end
            endcase
          end
        end
        humidity_link_pkg::st_hold: begin
          wait_cnt <= wait_cnt + 32'h0000_0001;
          if (wait_cnt == 32'(POWERUP_CYCLES - 1)) begin
            done      <= 1'b1;
            cmd_ready <= 1'b1;
            st        <= humidity_link_pkg::st_idle;
          end
        end
        humidity_link_pkg::st_cool: begin
          if (wait_cnt == 32'h0000_0000) begin
            cmd_ready <= 1'b1;
            st        <= humidity_link_pkg::st_idle;
          end else begin
            wait_cnt <= wait_cnt - 32'h0000_0001;
          end
        end
        default: st <= humidity_link_pkg::st_idle;
      endcase
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  sequence s_clk_pulse;
    ##[1:100] !sck ##[1:100] sck;
  endsequence

  sequence s_ts_open;
    $fell(sda_oe_n) && sck && st == humidity_link_pkg::st_ts;
  endsequence

  a_no_early_cmd: assert property ($rose(sck) |-> booted)
    else $error("Serial clock started before power-up wait ended.");
  a_change_after_fall: assert property (
    ($changed(sda_oe_n) && st != humidity_link_pkg::st_ts) |-> !sck)
    else $error("Data changed while serial clock was high.");
  a_stable_clk_high: assert property (
    (sck && $past(sck) && st != humidity_link_pkg::st_ts) |-> $stable(sda_oe_n))
    else $error("Data not stable during clock high.");
  a_only_pull_low: assert property (sda_out == 1'b0)
    else $error("Data output not held low.");
  a_frame_start_shape: assert property (
    s_ts_open |-> s_clk_pulse ##[1:100] ($rose(sda_oe_n) && sck))
    else $error("Frame start sequence malformed.");
  a_addr_bits_zero: assert property ((st == humidity_link_pkg::st_send && byte_cnt == 2'h0
    && bit_cnt < 4'(humidity_link_pkg::ADDR_BITS) && sck) |-> !sda_oe_n)
    else $error("Address bit not zero.");
  a_cmd_ack_release: assert property ((st == humidity_link_pkg::st_send
    && bit_cnt == 4'(humidity_link_pkg::ACK_SLOT) && sck) |-> sda_oe_n)
    else $error("Data not released in acknowledge slot.");
  a_wait_ready_idle: assert property (
    (st == humidity_link_pkg::st_wait_rdy) |=> (!sck && sda_oe_n))
    else $error("Clock or data active before data ready.");
  a_read_ack_low: assert property ((st == humidity_link_pkg::st_read
    && bit_cnt == 4'(humidity_link_pkg::ACK_SLOT) && sck && !end_early) |-> !sda_oe_n)
    else $error("Readout byte not acknowledged.");
  a_reset_released: assert property (
    (st == humidity_link_pkg::st_rst_clk) |-> sda_oe_n)
    else $error("Data driven during connection reset.");
  a_soft_rst_wait: assert property ((st == humidity_link_pkg::st_hold
    && $past(st) != humidity_link_pkg::st_hold) |-> !cmd_ready [*8])
    else $error("Ready raised too soon after soft reset.");
endmodule : humidity_host

// [humidity_dev_model.sv]
// Behavioural model of the humidity sensor on the two-wire link.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/100ps
module humidity_dev_model (
  input  wire logic sck,
  input  wire logic sda,
  input  wire logic slow,
  output logic      pull
);
  localparam logic [15:0] T_RAW  = 16'h3abc;
  localparam logic [15:0] RH_RAW = 16'h0e78;
  logic [7:0]  status;
  logic [7:0]  cmd;
  logic [7:0]  wb;
  logic [15:0] val;
  int          w;
  logic        got;
  event        ts_seen;

  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'h0} ^ 8'h31) : {r[6:0], 1'h0};
    end
    return r;
  endfunction : crc_step

  task automatic get_byte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge sck);
      b[i] = sda;
    end
  endtask : get_byte

  task automatic give_ack();
    @(negedge sck);
    pull = 1'h1;
    @(negedge sck);
    pull = 1'h0;
  endtask : give_ack

  task automatic send_byte(input logic [7:0] b, output logic ok);
    for (int i = 7; i >= 0; i--) begin
      pull = ~b[i];
      @(posedge sck);
      @(negedge sck);
    end
    pull = 1'h0;
    @(posedge sck);
    ok = ~sda;
    @(negedge sck);
  endtask : send_byte

  task automatic send_frame(input logic [15:0] v, input int n, input int dly);
    logic       ok;
    logic [7:0] c;
    c = crc_step(8'h00, cmd);
    if (dly > 0) begin
      #(dly);
      pull = 1'h1;
    end
    for (int k = n - 1; k >= 0; k--) begin
      c = crc_step(c, v[8*k +: 8]);
      send_byte(v[8*k +: 8], ok);
      if (!ok) begin
        return;
      end
    end
    send_byte(c, ok);
  endtask : send_frame

  always begin
    @(negedge sda iff sck === 1'h1);
    @(negedge sck);
    @(posedge sck);
    @(posedge sda iff sck === 1'h1);
    -> ts_seen;
  end

  initial begin
    pull   = 1'h0;
    status = 8'h00;
    got    = 1'h0;
    forever begin
      @(ts_seen);
      got = 1'h0;
      // A new frame start while a command is awaited restarts reception.
      while (!got) begin
        fork
          begin
            get_byte(cmd);
            got = 1'h1;
          end
          @(ts_seen);
        join_any
        disable fork;
      end
      if (cmd inside {8'h03, 8'h05, 8'h06, 8'h07, 8'h1e}) begin
        give_ack();
        case (cmd[4:0])
          5'h06: begin
            get_byte(wb);
            give_ack();
            status = wb & 8'h07;
          end
          5'h07: send_frame({8'h00, status}, 1, 0);
          5'h1e: status = 8'h00;
          default: begin
            w   = (cmd == 8'h03) ? (status[0] ? 12 : 14) : (status[0] ? 8 : 12);
            val = ((cmd == 8'h03) ? T_RAW : RH_RAW) & ~(16'hffff << w);
            send_frame(val, 2, slow ? 20000 : 1000);
          end
        endcase
      end
    end
  end
endmodule : humidity_dev_model

// [humidity_sensor_serial_port_bench.sv]
// Self-checking bench of the humidity link controller against a device model.
// Assumes the controller makes the link clock and the data line has a pull-up.
`timescale 1ns/100ps
module humidity_sensor_serial_port_bench;
  localparam int PWR = 50;
  logic        clk_sys = 1'h0;
  logic        arst_n, cmd_valid, skip_crc, link_reset, slow;
  logic [4:0]  cmd_code;
  logic [7:0]  wr_data;
  logic        sck, sda_out, sda_oe_n, cmd_ready, done, crc_ok, ack_err;
  logic [15:0] result;
  logic        dev_pull;
  logic        sda_line;
  logic        drove_high = 1'h0;
  int          err_total  = 0;
  int          n_tests    = 0;
  int          rises      = 0;
  int          n;

`define CHK(what, exp, got) begin \
  n_tests++; \
  if ((got) !== (exp)) begin \
    err_total++; \
    $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
  end \
end

  always #4 clk_sys = ~clk_sys;
  assign sda_line = (sda_oe_n ? 1'h1 : sda_out) & ~dev_pull;
  always @(posedge sck) begin
    rises++;
  end
  always @(negedge clk_sys) begin
    if (!sda_oe_n && sda_out !== 1'h0) drove_high = 1'h1;
  end

  humidity_host #(.POWERUP_CYCLES(PWR), .QUARTER(4)) u_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .wr_data(wr_data), .skip_crc(skip_crc), .link_reset(link_reset), .sda_in(sda_line),
    .sck(sck), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .cmd_ready(cmd_ready),
    .done(done), .result(result), .crc_ok(crc_ok), .ack_err(ack_err));
  humidity_dev_model u_dev (.sck(sck), .sda(sda_line), .slow(slow), .pull(dev_pull));

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  task automatic wait_ready(output int c);
    for (c = 0; c < 40000 && cmd_ready !== 1'h1; c++) begin
      @(negedge clk_sys);
    end
  endtask : wait_ready

  task automatic run_op(input logic [4:0] code, input logic [7:0] wd, input logic skip,
                        input logic lr);
    int c;
    wait_ready(c);
    cmd_code   = code;
    wr_data    = wd;
    skip_crc   = skip;
    link_reset = lr;
    cmd_valid  = ~lr;
    @(negedge clk_sys);
    cmd_valid  = 1'h0;
    link_reset = 1'h0;
    for (c = 0; c < 20000 && done !== 1'h1; c++) begin
      @(negedge clk_sys);
    end
    `CHK("done", 1'h1, done)
  endtask : run_op

  task automatic t_meas_temp();
    wait_ready(n);
    `CHK("powerup", 1'h1, n >= PWR)
    run_op(5'h03, 8'h00, 1'h0, 1'h0);
    `CHK("result", 16'h3abc, result)
    `CHK("crc_ok", 1'h1, crc_ok)
  endtask : t_meas_temp

  task automatic t_skip_slow();
    slow = 1'h1;
    run_op(5'h05, 8'h00, 1'h1, 1'h0);
    `CHK("result", 16'h0e78, result)
    `CHK("crc_ok", 1'h0, crc_ok)
    wait_ready(n);
    `CHK("cooldown", 1'h1, n >= 22000)
    slow = 1'h0;
  endtask : t_skip_slow

  task automatic t_status();
    run_op(5'h06, 8'h01, 1'h0, 1'h0);
    `CHK("ack_err", 1'h0, ack_err)
    run_op(5'h07, 8'h00, 1'h0, 1'h0);
    `CHK("status", 8'h01, result[7:0])
    `CHK("crc_ok", 1'h1, crc_ok)
    run_op(5'h05, 8'h00, 1'h0, 1'h0);
    `CHK("result", 16'h0078, result)
    run_op(5'h03, 8'h00, 1'h0, 1'h0);
    `CHK("result", 16'h0abc, result)
  endtask : t_status

  task automatic t_link_reset();
    rises = 0;
    run_op(5'h00, 8'h00, 1'h0, 1'h1);
    `CHK("clocks", 11, rises)
    run_op(5'h07, 8'h00, 1'h0, 1'h0);
    `CHK("status", 8'h01, result[7:0])
  endtask : t_link_reset

  task automatic t_soft_reset();
    run_op(5'h1e, 8'h00, 1'h0, 1'h0);
    `CHK("ack_err", 1'h0, ack_err)
    run_op(5'h07, 8'h00, 1'h0, 1'h0);
    `CHK("status", 8'h00, result[7:0])
  endtask : t_soft_reset

  task automatic t_no_ack();
    run_op(5'h0a, 8'h00, 1'h0, 1'h0);
    `CHK("ack_err", 1'h1, ack_err)
    rises = 0;
    run_op(5'h07, 8'h00, 1'h0, 1'h0);
    `CHK("ack_err", 1'h0, ack_err)
    `CHK("clocks", 1'h1, rises > 29)
  endtask : t_no_ack

  initial begin
    arst_n     = 1'h0;
    cmd_valid  = 1'h0;
    cmd_code   = 5'h00;
    wr_data    = 8'h00;
    skip_crc   = 1'h0;
    link_reset = 1'h0;
    slow       = 1'h0;
    repeat (6) @(negedge clk_sys);
    `CHK("ready", 1'h0, cmd_ready)
    arst_n = 1'h1;
    t_meas_temp();
    t_skip_slow();
    t_status();
    t_link_reset();
    t_soft_reset();
    t_no_ack();
    `CHK("drive", 1'h0, drove_high)
    finish_test();
  end

  initial begin
    #(800_000);
    err_total++;
    finish_test();
  end
endmodule : humidity_sensor_serial_port_bench
